// ---- verilog/turbo_decoder_control_status.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Command register resets to 0 and clears to 0 once a command is taken.
// - Start aborts work, clears pointers, raises first transmit event.
// - Code 4 initialises like start but keeps the noise result, then holds in MAP state zero.
// - Code 5 runs one MAP decode then holds in MAP state six.
// - Code 6 runs remaining MAP decodes and ends normally.
// - Code 7 resets registers except endianness, command and emulation.
// - Any fault stops processing and raises the decoder interrupt, selector 31.
// - Reading the fault register restores fault and status defaults.
// - Summary fault bit in both registers; status copy clears on start.
// - Single-device mode: frame length below 40 or above 20730 faults.
// - Split mode frame length checks per subframe kind.
// - Prolog above 48 faults; below 4 uses 24 silently.
// - Split mode subframe length above 20480 faults.
// - Reliability length checks per mode and kind.
// - Noise threshold above 100 faults.
// - Split mode table or params load request faults.
// - In a waiting phase, access to another memory faults; in the output parameter phase any access faults.
// - Minimum iterations above maximum faults.
// - Decoder-active bit is 0 in MAP state 0, else 1.
// - Separate waiting bits for each transfer phase.
// - After a decoding without output parameters, transmit event and configuration wait.
// - Status shows halt, second MAP, state, iteration, noise result.
module turbo_decoder_control_status
  import tdec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_valid,
  input wire logic [2:0] mem_sel,
  input wire logic mem_last,
  input wire logic snr_exceed_in,
  input wire logic emu_halt_pin,
  output logic transmit_event,
  output logic receive_event,
  output logic decoder_irq
);
  logic [2:0] cmd_q;
  logic [31:0] cfg0_q, cfg1_q, cfg2_q, endian_q, emu_q, prdata_q;
  logic [nfault-1:0] fault_q, set_vec;
  logic [nfault-1:1] cause;
  logic err_stat_q, snr_q, emu_s1_q, emu_s2_q, halted;
  logic transmit_event_q, revt_q, map_q, dbg_q, last_map;
  logic [3:0] map_state_q;
  logic [4:0] iter_q;
  state_t st_q;
  logic acc, wr, rd, fault_rd, soft_rst, rd_hit;
  logic [31:0] rd_data, stat;
  logic [14:0] fl, sf;
  logic [5:0] pl, eff_pl, eff_max;
  logic [7:0] rl, rl_m1, snr_thr;
  logic [4:0] min_it;
  logic [1:0] kind;
  logic split, cfg_check, stray, in_wait;
  logic frame_bad, rel_bad;
  logic [2:0] exp_sel;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign fault_rd = rd && paddr == adr_fault;
  assign soft_rst = cmd_q == cmd_soft_rst;
  assign pready = 1'b1;
  assign pslverr = acc & ~rd_hit;
  assign prdata = prdata_q;
  assign transmit_event = transmit_event_q;
  assign receive_event = revt_q;
  assign decoder_irq = fault_q[f_sum];

  // Emulation halt pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emu_s1_q <= 1'b0;
      emu_s2_q <= 1'b0;
    end else begin
      emu_s1_q <= emu_halt_pin;
      emu_s2_q <= emu_s1_q;
    end
  end
  // Bit 0 of the emulation register lets decoding run through a halt
  assign halted = emu_s2_q & ~emu_q[0];

  // Command register: taken one cycle, then written back to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= cmd_none;
    end else if (wr && paddr == adr_cmd) begin
      cmd_q <= pwdata[2:0];
    end else begin
      cmd_q <= cmd_none;
    end
  end

  AST_CMD_ACCEPT: assert property (
    (cmd_q != cmd_none && !(wr && paddr == adr_cmd)) |=> cmd_q == cmd_none)
    else $error("command not written back to idle");

  // Configuration; endianness and emulation survive a soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= reg_rst;
      cfg1_q <= reg_rst;
      cfg2_q <= reg_rst;
    end else if (soft_rst) begin
      cfg0_q <= reg_rst;
      cfg1_q <= reg_rst;
      cfg2_q <= reg_rst;
    end else if (wr) begin
      if (paddr == adr_cfg0) cfg0_q <= pwdata;
      if (paddr == adr_cfg1) cfg1_q <= pwdata;
      if (paddr == adr_cfg2) cfg2_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endian_q <= reg_rst;
      emu_q <= reg_rst;
    end else if (wr) begin
      if (paddr == adr_endian) endian_q <= pwdata;
      if (paddr == adr_emu) emu_q <= pwdata;
    end
  end

  assign fl = cfg0_q[c0_fl +: 15];
  assign split = cfg0_q[c0_split];
  assign kind = cfg0_q[c0_kind +: 2];
  assign pl = cfg1_q[c1_pl +: 6];
  assign sf = cfg1_q[c1_sf +: 15];
  assign rl = cfg2_q[c2_rl +: 8];
  assign rl_m1 = rl - 8'h01;
  assign snr_thr = cfg2_q[c2_snr +: 8];
  assign min_it = cfg2_q[c2_min +: 5];
  assign eff_pl = (pl < pl_min) ? pl_default : pl;
  assign eff_max = (cfg2_q[c2_max +: 5] == 5'h00) ? iter_full :
                   {1'b0, cfg2_q[c2_max +: 5]};

  // Parameter checks, applied when the configuration words land
  always_comb begin
    frame_bad = 1'b0;
    rel_bad = 1'b0;
    if (!split) begin
      frame_bad = fl < sa_fl_min || fl > sa_fl_max;
      rel_bad = rl == 8'h00 || rl_m1 < rel_sa_min ||
                rl_m1 > rel_sa_max;
    end else if (kind == kind_last) begin
      frame_bad = fl < sp_fl_min3 || fl > sp_fl_max;
      rel_bad = rl < rel_sp3_min;
    end else if (kind != kind_none) begin
      frame_bad = fl < sp_fl_min12 || fl > sp_fl_max ||
                  fl[sp_fl_step_bits-1:0] != '0;
      rel_bad = rl != rel_sp12;
    end
  end

  assign cfg_check = st_q == st_wait_cfg && mem_valid && mem_last &&
                     mem_sel == mem_config;

  // Expected memory for each waiting phase
  always_comb begin
    in_wait = 1'b1;
    exp_sel = mem_config;
    case (st_q)
      st_wait_cfg: exp_sel = mem_config;
      st_wait_tbl: exp_sel = mem_table;
      st_wait_sp: exp_sel = mem_sys_parity;
      st_wait_ap: exp_sel = mem_apriori;
      st_read_ext: exp_sel = mem_extrinsic;
      st_read_hd: exp_sel = mem_decision;
      st_read_op: exp_sel = mem_outparam;
      default: in_wait = 1'b0;
    endcase
  end
  assign stray = mem_valid && in_wait &&
                 (st_q == st_read_op || mem_sel != exp_sel);

  always_comb begin
    cause = '0;
    cause[f_frame] = cfg_check & frame_bad;
    cause[f_prolog] = cfg_check && pl > pl_max;
    cause[f_sub] = cfg_check && split && sf > sf_max;
    cause[f_rel] = cfg_check & rel_bad;
    cause[f_snr] = cfg_check && snr_thr > snr_max;
    cause[f_table] = cfg_check & split & cfg0_q[c0_tbl];
    cause[f_params] = cfg_check & split & cfg0_q[c0_op];
    cause[f_stray] = stray;
    cause[f_iter] = cfg_check && {1'b0, min_it} > eff_max;
    set_vec = {cause, |cause};
  end

  // Sticky faults; a new fault outranks the read that clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
    end else if (soft_rst) begin
      fault_q <= '0;
    end else begin
      fault_q <= (fault_rd ? '0 : fault_q) | set_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_stat_q <= 1'b0;
    end else if (soft_rst) begin
      err_stat_q <= 1'b0;
    end else if (set_vec[f_sum]) begin
      err_stat_q <= 1'b1;
    end else if (fault_rd || cmd_q == cmd_start ||
                 cmd_q == cmd_dbg_init) begin
      err_stat_q <= 1'b0;
    end
  end

  AST_SUMMARY: assert property (
    fault_q != '0 |-> fault_q[f_sum] && decoder_irq)
    else $error("summary fault bit missing");
  AST_READ_CLEARS: assert property (
    (fault_rd && set_vec == '0 && cmd_q == cmd_none)
    |=> fault_q == '0 && !err_stat_q && st_q == st_idle)
    else $error("fault read did not restore defaults");
  AST_FRAME_SA: assert property (
    (cfg_check && !split && (fl < sa_fl_min || fl > sa_fl_max) &&
     cmd_q == cmd_none) |=> fault_q[f_frame])
    else $error("frame length fault missed");
  AST_PROLOG: assert property (
    (cfg_check && pl < pl_min) |-> eff_pl == pl_default && !cause[f_prolog])
    else $error("short prolog not replaced");
  AST_STRAY: assert property (
    (mem_valid && cmd_q == cmd_none && (st_q == st_read_op ||
     (st_q == st_wait_cfg && mem_sel != mem_config)))
    |=> fault_q[f_stray] ##1 decoder_irq)
    else $error("stray access not flagged");

  assign last_map = map_q && ({1'b0, iter_q} + 6'h01) == eff_max;

  // Sequencer, MAP counters and DMA events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= st_idle;
      map_state_q <= map_idle;
      iter_q <= 5'h00;
      map_q <= 1'b0;
      dbg_q <= 1'b0;
      transmit_event_q <= 1'b0;
      revt_q <= 1'b0;
    end else begin
      transmit_event_q <= 1'b0;
      revt_q <= 1'b0;
      if (soft_rst) begin
        st_q <= st_idle;
        map_state_q <= map_idle;
        iter_q <= 5'h00;
        map_q <= 1'b0;
        dbg_q <= 1'b0;
      end else if (cmd_q == cmd_start || cmd_q == cmd_dbg_init) begin
        st_q <= st_wait_cfg;
        map_state_q <= map_idle;
        iter_q <= 5'h00;
        map_q <= 1'b0;
        dbg_q <= cmd_q == cmd_dbg_init;
        transmit_event_q <= 1'b1;
      end else if (set_vec[f_sum]) begin
        st_q <= st_fault;
      end else if (fault_rd) begin
        st_q <= st_idle;
        map_state_q <= map_idle;
        iter_q <= 5'h00;
        map_q <= 1'b0;
      end else begin
        case (st_q)
          st_wait_cfg: if (cfg_check) begin
            st_q <= cfg0_q[c0_tbl] ? st_wait_tbl : st_wait_sp;
          end
          st_wait_tbl: if (mem_valid && mem_last) begin
            st_q <= st_wait_sp;
          end
          st_wait_sp, st_wait_ap: if (mem_valid && mem_last) begin
            if (st_q == st_wait_sp && split) begin
              st_q <= st_wait_ap;
            end else if (dbg_q) begin
              st_q <= st_hold;
            end else begin
              st_q <= st_decode;
              map_state_q <= map_first;
            end
          end
          st_hold: if (cmd_q == cmd_dbg_one ||
                       cmd_q == cmd_dbg_rest) begin
            st_q <= st_decode;
            map_state_q <= map_first;
            dbg_q <= cmd_q == cmd_dbg_one;
          end
          st_decode: if (!halted) begin
            if (map_state_q != map_last) begin
              map_state_q <= map_state_q + 4'h1;
            end else if (last_map) begin
              map_state_q <= map_idle;
              st_q <= split ? st_read_ext : st_read_hd;
              revt_q <= 1'b1;
            end else begin
              map_q <= ~map_q;
              if (map_q) iter_q <= iter_q + 5'h01;
              if (dbg_q) begin
                st_q <= st_hold;
                map_state_q <= map_hold;
              end else begin
                map_state_q <= map_first;
              end
            end
          end
          st_read_ext: if (mem_valid && mem_last) begin
            st_q <= st_read_hd;
            revt_q <= 1'b1;
          end
          st_read_hd, st_read_op: if (mem_valid && mem_last) begin
            if (st_q == st_read_hd && cfg0_q[c0_op]) begin
              st_q <= st_read_op;
              revt_q <= 1'b1;
            end else begin
              st_q <= st_wait_cfg;
              transmit_event_q <= 1'b1;
              iter_q <= 5'h00;
              map_q <= 1'b0;
            end
          end
          // Codes 2 and 3 and unused states leave everything alone
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // Noise result of the latest finished MAP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snr_q <= 1'b0;
    end else if (soft_rst || fault_rd || cmd_q == cmd_start) begin
      snr_q <= 1'b0;
    end else if (st_q == st_decode && map_state_q == map_last) begin
      snr_q <= snr_exceed_in;
    end
  end

  sequence start_taken;
    cmd_q == cmd_start;
  endsequence
  sequence step_map_end;
    st_q == st_decode && !halted && map_state_q == map_last && dbg_q &&
    !last_map && cmd_q == cmd_none && set_vec == '0;
  endsequence
  property p_start;
    start_taken |=> transmit_event && st_q == st_wait_cfg && iter_q == 5'h00
      ##1 !transmit_event;
  endproperty
  property p_step;
    step_map_end |=> st_q == st_hold && map_state_q == map_hold;
  endproperty

  AST_START_EVENT: assert property (p_start)
    else $error("start did not raise one transmit event");
  AST_STEP_HOLD: assert property (p_step)
    else $error("single step did not hold in state six");
  AST_DBG_HOLD: assert property (
    (cmd_q == cmd_dbg_init) |=> dbg_q && st_q == st_wait_cfg)
    else $error("debug init not armed");
  AST_RUN_REST: assert property (
    (st_q == st_hold && cmd_q == cmd_dbg_rest && set_vec == '0)
    |=> st_q == st_decode && !dbg_q && map_state_q == map_first)
    else $error("run of remaining decodes not started");
  AST_SOFT_RESET: assert property (
    (cmd_q == cmd_soft_rst) |=> st_q == st_idle && fault_q == '0 &&
    cfg0_q == reg_rst && $stable(endian_q))
    else $error("soft reset incomplete");
  AST_FAULT_STOP: assert property (
    (set_vec[f_sum] && cmd_q == cmd_none) |=> st_q == st_fault && decoder_irq
    ##1 st_q == st_fault || fault_rd || $past(fault_rd))
    else $error("fault did not stop the decoder");
  AST_NOOP: assert property (
    (cmd_q == 3'h2 || cmd_q == 3'h3) && set_vec == '0 && st_q == st_hold
    |=> st_q == st_hold)
    else $error("undefined command changed state");

  // Status word
  always_comb begin
    stat = '0;
    stat[s_busy] = map_state_q != map_idle;
    stat[s_err] = err_stat_q;
    stat[s_wcfg] = st_q == st_wait_cfg;
    stat[s_wtbl] = st_q == st_wait_tbl;
    stat[s_wsp] = st_q == st_wait_sp;
    stat[s_wap] = st_q == st_wait_ap;
    stat[s_await_extrinsic_read] = st_q == st_read_ext;
    stat[s_rhd] = st_q == st_read_hd;
    stat[s_rop] = st_q == st_read_op;
    stat[s_emu] = halted;
    stat[s_map] = map_q;
    stat[s_snr] = snr_q;
    stat[s_state +: 4] = map_state_q;
    stat[s_iter +: 5] = iter_q;
    stat[s_prolog +: 6] = eff_pl;
  end

  AST_BUSY: assert property (
    !(st_q inside {st_hold, st_fault}) |-> stat[s_busy] == (st_q == st_decode))
    else $error("busy set in MAP state zero");

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      adr_cmd: rd_data = {29'h0, cmd_q};
      adr_fault: rd_data = {{(32-nfault){1'b0}}, fault_q};
      adr_stat: rd_data = stat;
      adr_cfg0: rd_data = cfg0_q;
      adr_cfg1: rd_data = cfg1_q;
      adr_cfg2: rd_data = cfg2_q;
      adr_endian: rd_data = endian_q;
      adr_emu: rd_data = emu_q;
      default: begin
        rd_data = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_data;
    end
  end
endmodule // turbo_decoder_control_status

// ---- shared/tdec_pkg.sv ----
package tdec_pkg;
  // Register byte offsets
  localparam logic [7:0] adr_cmd = 8'h00;
  localparam logic [7:0] adr_fault = 8'h04;
  localparam logic [7:0] adr_stat = 8'h08;
  localparam logic [7:0] adr_cfg0 = 8'h0c;
  localparam logic [7:0] adr_cfg1 = 8'h10;
  localparam logic [7:0] adr_cfg2 = 8'h14;
  localparam logic [7:0] adr_endian = 8'h18;
  localparam logic [7:0] adr_emu = 8'h1c;
  localparam logic [31:0] reg_rst = 32'h0000_0000;
  // Command codes
  localparam logic [2:0] cmd_none = 3'h0;
  localparam logic [2:0] cmd_start = 3'h1;
  localparam logic [2:0] cmd_dbg_init = 3'h4;
  localparam logic [2:0] cmd_dbg_one = 3'h5;
  localparam logic [2:0] cmd_dbg_rest = 3'h6;
  localparam logic [2:0] cmd_soft_rst = 3'h7;
  // Selector of the decoder interrupt at the system controller
  localparam int irq_selector = 31;
  // Parameter limits
  localparam logic [14:0] sa_fl_min = 15'h0028;
  localparam logic [14:0] sa_fl_max = 15'h50fa;
  localparam logic [14:0] sp_fl_min12 = 15'h0100;
  localparam logic [14:0] sp_fl_min3 = 15'h0080;
  localparam logic [14:0] sp_fl_max = 15'h5000;
  localparam int sp_fl_step_bits = 8;
  localparam logic [14:0] sf_max = 15'h5000;
  localparam logic [5:0] pl_max = 6'h30;
  localparam logic [5:0] pl_min = 6'h04;
  localparam logic [5:0] pl_default = 6'h18;
  localparam logic [7:0] rel_sa_min = 8'h28;
  localparam logic [7:0] rel_sa_max = 8'h80;
  localparam logic [7:0] rel_sp12 = 8'h80;
  localparam logic [7:0] rel_sp3_min = 8'h41;
  localparam logic [7:0] snr_max = 8'h64;
  localparam logic [5:0] iter_full = 6'h20;
  localparam logic [1:0] kind_none = 2'h0;
  localparam logic [1:0] kind_last = 2'h3;
  // Memory selectors seen on the transfer port
  localparam logic [2:0] mem_config = 3'h0;
  localparam logic [2:0] mem_table = 3'h1;
  localparam logic [2:0] mem_sys_parity = 3'h2;
  localparam logic [2:0] mem_apriori = 3'h3;
  localparam logic [2:0] mem_extrinsic = 3'h4;
  localparam logic [2:0] mem_decision = 3'h5;
  localparam logic [2:0] mem_outparam = 3'h6;
  // MAP decoder states
  localparam logic [3:0] map_idle = 4'h0;
  localparam logic [3:0] map_first = 4'h1;
  localparam logic [3:0] map_hold = 4'h6;
  localparam logic [3:0] map_last = 4'h8;
  // Fault register bits
  localparam int f_sum = 0;
  localparam int f_frame = 1;
  localparam int f_prolog = 2;
  localparam int f_sub = 3;
  localparam int f_rel = 4;
  localparam int f_snr = 5;
  localparam int f_table = 6;
  localparam int f_params = 7;
  localparam int f_stray = 8;
  localparam int f_iter = 9;
  localparam int nfault = 10;
  // Status register bits
  localparam int s_busy = 0;
  localparam int s_err = 1;
  localparam int s_wcfg = 2;
  localparam int s_wtbl = 3;
  localparam int s_wsp = 4;
  localparam int s_wap = 5;
  localparam int s_await_extrinsic_read = 6;
  localparam int s_rhd = 7;
  localparam int s_rop = 8;
  localparam int s_emu = 9;
  localparam int s_map = 10;
  localparam int s_snr = 11;
  localparam int s_state = 12;
  localparam int s_iter = 16;
  localparam int s_prolog = 24;
  // Configuration field positions
  localparam int c0_fl = 0;
  localparam int c0_split = 16;
  localparam int c0_kind = 17;
  localparam int c0_tbl = 19;
  localparam int c0_op = 20;
  localparam int c1_pl = 0;
  localparam int c1_sf = 16;
  localparam int c2_rl = 0;
  localparam int c2_snr = 8;
  localparam int c2_min = 16;
  localparam int c2_max = 24;
  typedef enum logic [3:0] {
    st_idle, st_wait_cfg, st_wait_tbl, st_wait_sp, st_wait_ap, st_hold,
    st_decode, st_read_ext, st_read_hd, st_read_op, st_fault
  } state_t;
endpackage

// ---- tb/dma_model.sv ----
`timescale 1ns/1ps
// Transfer engine on the far side: plays beats into one memory per phase
module dma_model
  import tdec_pkg::*;
(
  input wire logic pclk,
  output logic mem_valid,
  output logic [2:0] mem_sel,
  output logic mem_last
);
  initial begin
    mem_valid = 1'b0;
    mem_sel = 3'h7;
    mem_last = 1'b0;
  end

  // Call just after a rising edge; gap idles that many cycles between beats
  task automatic burst(input logic [2:0] s, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      mem_valid <= 1'b1;
      mem_sel <= s;
      mem_last <= (i == n - 1);
      @(posedge pclk);
      for (int g = 0; g < gap && i < n - 1; g++) begin
        mem_valid <= 1'b0;
        mem_sel <= ~mem_sel;
        mem_last <= 1'b1;
        @(posedge pclk);
      end
    end
    // Released lines show a changed value, not the last beat
    mem_valid <= 1'b0;
    mem_sel <= ~s;
    mem_last <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // dma_model

// ---- tb/turbo_decoder_control_status_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch at %0t: got %h exp %h", $time, g, e); \
  end end
module turbo_decoder_control_status_bench;
  import tdec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic mem_valid, mem_last, snr_exceed_in, emu_halt_pin;
  logic [2:0] mem_sel;
  logic transmit_event, receive_event, decoder_irq;
  int n_mismatch, checks_done, n_tx, n_rx, t0, r0;
  logic [31:0] tbl [0:10][0:2] = '{
    '{32'd39, 32'h18, 32'h0101_0064}, '{32'd20731, 32'h18, 32'h0101_0064},
    '{32'd20730, 32'h18, 32'h0101_0029}, '{32'd40, 32'h3, 32'h0101_0028},
    '{32'h0003_0101, 32'h18, 32'h0101_0080},
    '{32'h0005_5000, 32'h18, 32'h0101_007f},
    '{32'h0007_0080, 32'h5001_0018, 32'h0101_0041},
    '{32'd100, 32'h31, 32'h0101_6564}, '{32'd100, 32'h30, 32'h0102_0000},
    '{32'h0009_0100, 32'h18, 32'h0001_0080},
    '{32'h0013_0100, 32'h18, 32'h001f_0080}};

  turbo_decoder_control_status uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_valid(mem_valid), .mem_sel(mem_sel), .mem_last(mem_last),
    .snr_exceed_in(snr_exceed_in), .emu_halt_pin(emu_halt_pin),
    .transmit_event(transmit_event), .receive_event(receive_event),
    .decoder_irq(decoder_irq));
  dma_model dma (.pclk(pclk), .mem_valid(mem_valid), .mem_sel(mem_sel),
    .mem_last(mem_last));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (transmit_event === 1'b1) n_tx++;
    if (receive_event === 1'b1) n_rx++;
  end

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, adr_stat, 32'h0);
      n++;
    end while ((q & m) !== v && n < 200);
    `CHK(q & m, v)
    if ((q & m) !== v) finish_test();
  endtask

  function automatic logic [31:0] exp_fault(input logic [31:0] c0, c1, c2);
    logic [31:0] f;
    int fl, rl, mx;
    logic [1:0] k;
    f = 32'h0;
    fl = c0[14:0];
    k = c0[18:17];
    rl = c2[7:0];
    mx = (c2[28:24] == 5'h0) ? 32 : c2[28:24];
    if (!c0[c0_split]) f[f_frame] = fl < 40 || fl > 20730;
    else if (k != 2'h0) f[f_frame] = fl > 20480 ||
      (k == 2'h3 ? fl < 128 : (fl < 256 || fl % 256 != 0));
    f[f_prolog] = c1[5:0] > 48;
    f[f_sub] = c0[c0_split] && c1[30:16] > 20480;
    if (!c0[c0_split]) f[f_rel] = rl - 1 < 40 || rl - 1 > 128;
    else if (k != 2'h0) f[f_rel] = (k == 2'h3) ? rl < 65 : rl != 128;
    f[f_snr] = c2[15:8] > 100;
    f[f_table] = c0[c0_split] && c0[c0_tbl];
    f[f_params] = c0[c0_split] && c0[c0_op];
    f[f_iter] = c2[20:16] > mx;
    f[f_sum] = |f;
    return f;
  endfunction

  task automatic cfg_run(input logic [31:0] c0, c1, c2);
    logic [31:0] e;
    e = exp_fault(c0, c1, c2);
    apb(1'b1, adr_cfg0, c0);
    apb(1'b1, adr_cfg1, c1);
    apb(1'b1, adr_cfg2, c2);
    apb(1'b1, adr_cmd, {29'h0, cmd_start});
    repeat (2) @(posedge pclk);
    dma.burst(mem_config, 3, 0);
    repeat (2) @(posedge pclk);
    `CHK(decoder_irq, e[f_sum])
    apb(1'b0, adr_stat, 32'h0);
    `CHK(q[s_err], e[f_sum])
    apb(1'b0, adr_fault, 32'h0);
    `CHK(q, e)
    apb(1'b0, adr_stat, 32'h0);
    `CHK(q[15:0], 16'h0)
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, snr_exceed_in, emu_halt_pin} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    void'($urandom(27627));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, adr_cmd, 32'h0);
    `CHK(q, 32'h0)
    t0 = n_tx;
    apb(1'b1, adr_cmd, {29'h0, cmd_start});
    repeat (3) @(posedge pclk);
    `CHK(n_tx - t0, 1)
    apb(1'b0, adr_cmd, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, adr_stat, 32'h0);
    `CHK(q[s_wcfg], 1'b1)
    apb(1'b1, 8'h40, 32'hffff_ffff);
    `CHK(err_q, 1'b1)
    $display("test start done");
    for (int i = 0; i < 11; i++) cfg_run(tbl[i][0], tbl[i][1], tbl[i][2]);
    for (int i = 0; i < 20; i++) cfg_run($urandom & 32'h0007_7fff,
      $urandom & 32'h7fff_003f, $urandom & 32'h1f1f_ffff);
    $display("test config checks done");
    for (int k = 1; k < 7; k++) begin
      apb(1'b1, adr_cmd, {29'h0, cmd_start});
      repeat (2) @(posedge pclk);
      dma.burst(3'(k), 1, 0);
      repeat (2) @(posedge pclk);
      `CHK(decoder_irq, 1'b1)
      apb(1'b1, adr_cmd, {29'h0, cmd_start});
      apb(1'b0, adr_stat, 32'h0);
      `CHK(q[s_err], 1'b0)
      apb(1'b0, adr_fault, 32'h0);
      `CHK(q, 32'h0000_0101)
    end
    $display("test stray access done");
    apb(1'b1, adr_cfg0, 32'd40 + $urandom % 20691);
    apb(1'b1, adr_cfg1, 32'h2);
    apb(1'b1, adr_cfg2, 32'h0101_0064);
    t0 = n_tx;
    r0 = n_rx;
    apb(1'b1, adr_cmd, {29'h0, cmd_start});
    repeat (2) @(posedge pclk);
    dma.burst(mem_config, 4, 2);
    poll(32'h1 << s_wsp, 32'h1 << s_wsp);
    `CHK(q[29:24], pl_default)
    snr_exceed_in <= 1'b1;
    dma.burst(mem_sys_parity, 4, 0);
    poll(32'h1 << s_busy, 32'h1 << s_busy);
    poll(32'h1 << s_map, 32'h1 << s_map);
    poll(32'h1 << s_rhd, 32'h1 << s_rhd);
    `CHK(q[s_snr], 1'b1)
    `CHK(n_rx - r0, 1)
    dma.burst(mem_decision, 4, 1);
    poll(32'h1 << s_wcfg, 32'h1 << s_wcfg);
    `CHK(n_tx - t0, 2)
    $display("test full decode done");
    apb(1'b1, adr_cmd, {29'h0, cmd_dbg_init});
    repeat (2) @(posedge pclk);
    dma.burst(mem_config, 2, 0);
    dma.burst(mem_sys_parity, 2, 0);
    repeat (30) @(posedge pclk);
    apb(1'b0, adr_stat, 32'h0);
    s = q;
    `CHK(q[15:12], map_idle)
    `CHK(q[s_busy], 1'b0)
    apb(1'b1, adr_cmd, 32'h2);
    apb(1'b1, adr_cmd, 32'h3);
    repeat (2) @(posedge pclk);
    apb(1'b0, adr_stat, 32'h0);
    `CHK(q, s)
    apb(1'b1, adr_cmd, {29'h0, cmd_dbg_one});
    poll(32'h0000_f000, {16'h0, map_hold, 12'h0});
    repeat (20) @(posedge pclk);
    poll(32'h0000_f001, {16'h0, map_hold, 12'h1});
    apb(1'b1, adr_cmd, {29'h0, cmd_dbg_rest});
    poll(32'h1 << s_rhd, 32'h1 << s_rhd);
    $display("test debug steps done");
    emu_halt_pin <= 1'b1;
    poll(32'h1 << s_emu, 32'h1 << s_emu);
    emu_halt_pin <= 1'b0;
    s = $urandom;
    apb(1'b1, adr_endian, s);
    apb(1'b1, adr_cfg0, 32'h1234);
    apb(1'b1, adr_cmd, {29'h0, cmd_soft_rst});
    repeat (3) @(posedge pclk);
    apb(1'b0, adr_cfg0, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, adr_endian, 32'h0);
    `CHK(q, s)
    apb(1'b0, adr_cmd, 32'h0);
    `CHK(q, 32'h0)
    $display("test soft reset done");
    finish_test();
  end
endmodule // turbo_decoder_control_status_bench
